// [hdl/shader_stream_switch_map.sv]
// Switch map registers and stream sequencer of the pixel shader, with an AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
module shader_stream_switch_map (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Sequencer.
	input wire logic seq_start,
	input wire logic start_stream,
	input wire logic instr_issued,
	output logic current_stream,
	output logic [6:0] tex_index,
	output logic [6:0] arith_index,
	output logic switch_pulse
);
	logic [23:0] tex_map_q;
	logic [23:0] arith_map_0_q;
	logic [23:0] arith_map_1_q;
	logic [23:0] arith_map_2_q;
	logic wr_pend_q;
	logic [9:0] wr_addr_q;
	logic [31:0] hrdata_q;
	stream_switch_pkg::stream_t stream_q;
	stream_switch_pkg::stream_t stream_d;
	logic [6:0] tex_idx_q;
	logic [6:0] tex_idx_d;
	logic [6:0] arith_idx_q;
	logic [6:0] arith_idx_d;
	logic switch_q;
	logic switch_d;
	logic flag;

	// Bus decode; only whole-word transfers are expected, other sizes act the same.
	wire logic addr_phase = hsel && hready && (htrans == stream_switch_pkg::HTRANS_NONSEQ ||
		htrans == 2'h3);
	wire logic [9:0] a = {haddr[9:2], 2'h0};
	wire logic [31:0] status_word = {15'h0000, stream_q,
		1'b0, arith_idx_q, 1'b0, tex_idx_q};
	wire logic [31:0] rd_word =
		(a == stream_switch_pkg::ADDR_TEX_TO_ARITH_SWITCH_HI) ? {8'h00, tex_map_q} :
		(a == stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_0) ? {8'h00, arith_map_0_q} :
		(a == stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_1) ? {8'h00, arith_map_1_q} :
		(a == stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_2) ? {8'h00, arith_map_2_q} :
		(a == stream_switch_pkg::ADDR_SEQ_STATUS) ? status_word : 32'h00000000;
	wire logic [23:0] wmap = hwdata[23:0];
	wire logic wr_tex = wr_pend_q && wr_addr_q == stream_switch_pkg::ADDR_TEX_TO_ARITH_SWITCH_HI;
	wire logic wr_a0 = wr_pend_q && wr_addr_q == stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_0;
	wire logic wr_a1 = wr_pend_q && wr_addr_q == stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_1;
	wire logic wr_a2 = wr_pend_q && wr_addr_q == stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_2;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 10'h000;
			hrdata_q <= 32'h00000000;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			wr_addr_q <= a;
			hrdata_q <= (addr_phase && !hwrite) ? rd_word : 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tex_map_q <= stream_switch_pkg::MAP_RESET;
			arith_map_0_q <= stream_switch_pkg::MAP_RESET;
			arith_map_1_q <= stream_switch_pkg::MAP_RESET;
			arith_map_2_q <= stream_switch_pkg::MAP_RESET;
		end else begin
			if (wr_tex) begin
				tex_map_q <= wmap & stream_switch_pkg::TEX_SWITCH_MASK;
			end
			if (wr_a0) begin
				arith_map_0_q <= wmap;
			end
			if (wr_a1) begin
				arith_map_1_q <= wmap;
			end
			if (wr_a2) begin
				arith_map_2_q <= wmap;
			end
		end
	end

	switch_flag_select u_select (
		.tex_map(tex_map_q),
		.arith_map_0(arith_map_0_q),
		.arith_map_1(arith_map_1_q),
		.arith_map_2(arith_map_2_q),
		.stream(stream_q),
		.tex_index(tex_idx_q),
		.arith_index(arith_idx_q),
		.flag(flag)
	);

	// A completed instruction advances its own stream index; in the same cycle its flag, at the old index, decides the stream.
	always_comb begin
		stream_d = stream_q;
		tex_idx_d = tex_idx_q;
		arith_idx_d = arith_idx_q;
		switch_d = 1'b0;
		if (seq_start) begin
			stream_d = start_stream ? stream_switch_pkg::STREAM_ARITH :
				stream_switch_pkg::STREAM_TEX;
			tex_idx_d = 7'h00;
			arith_idx_d = 7'h00;
		end else if (instr_issued) begin
			if (stream_q == stream_switch_pkg::STREAM_TEX) begin
				tex_idx_d = tex_idx_q + 7'h01;
			end else begin
				arith_idx_d = arith_idx_q + 7'h01;
			end
			if (flag) begin
				stream_d = (stream_q == stream_switch_pkg::STREAM_TEX) ?
					stream_switch_pkg::STREAM_ARITH : stream_switch_pkg::STREAM_TEX;
				switch_d = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stream_q <= stream_switch_pkg::STREAM_TEX;
			tex_idx_q <= 7'h00;
			arith_idx_q <= 7'h00;
			switch_q <= 1'b0;
		end else begin
			stream_q <= stream_d;
			tex_idx_q <= tex_idx_d;
			arith_idx_q <= arith_idx_d;
			switch_q <= switch_d;
		end
	end

	assign current_stream = stream_q;
	assign tex_index = tex_idx_q;
	assign arith_index = arith_idx_q;
	assign switch_pulse = switch_q;
endmodule // shader_stream_switch_map
`default_nettype wire

// [hdl/stream_switch_pkg.sv]
// Constants shared by the shader stream switch map block.
// Summary of operation
// - tex_to_arith_switch_hi bits 7:0 switch texture instructions 24..31; 23:8 reserved.
// - Arithmetic flag read after its instruction: 0 continues, 1 goes to texture stream.
// - arith_to_tex_switch_0 bit k is the arithmetic switch flag of instruction k.
// - arith_to_tex_switch_1 bit k is the arithmetic switch flag of instruction 24+k.
// - arith_to_tex_switch_2 serves instructions 48..71; bit 23 is 71, bit 13 is 61.
`default_nettype none
package stream_switch_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned MAP_W = 24;
	localparam int unsigned IDX_W = 7;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_TEX_TO_ARITH_SWITCH_HI = 8'h94;
	localparam logic [7:0] IDX_ARITH_TO_TEX_SWITCH_0 = 8'h95;
	localparam logic [7:0] IDX_ARITH_TO_TEX_SWITCH_1 = 8'h96;
	localparam logic [7:0] IDX_ARITH_TO_TEX_SWITCH_2 = 8'h97;
	localparam logic [7:0] IDX_SEQ_STATUS = 8'hA0;
	localparam logic [9:0] ADDR_TEX_TO_ARITH_SWITCH_HI = {IDX_TEX_TO_ARITH_SWITCH_HI, 2'h0};
	localparam logic [9:0] ADDR_ARITH_TO_TEX_SWITCH_0 = {IDX_ARITH_TO_TEX_SWITCH_0, 2'h0};
	localparam logic [9:0] ADDR_ARITH_TO_TEX_SWITCH_1 = {IDX_ARITH_TO_TEX_SWITCH_1, 2'h0};
	localparam logic [9:0] ADDR_ARITH_TO_TEX_SWITCH_2 = {IDX_ARITH_TO_TEX_SWITCH_2, 2'h0};
	localparam logic [9:0] ADDR_SEQ_STATUS = {IDX_SEQ_STATUS, 2'h0};
	// Field layout of the texture switch register.
	localparam logic [23:0] TEX_SWITCH_MASK = 24'h0000FF;
	localparam logic [6:0] TEX_FLAG_BASE = 7'h18;
	localparam logic [6:0] TEX_FLAG_LAST = 7'h1F;
	// Arithmetic index bases for the three arithmetic registers.
	localparam logic [6:0] ARITH_BASE_1 = 7'h18;
	localparam logic [6:0] ARITH_BASE_2 = 7'h30;
	localparam logic [6:0] ARITH_LAST = 7'h47;
	// Status field positions.
	localparam int unsigned STAT_STREAM_BIT = 16;
	localparam int unsigned STAT_ARITH_LSB = 8;
	localparam int unsigned STAT_TEX_LSB = 0;
	localparam logic [23:0] MAP_RESET = 24'h000000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [0:0] {
		STREAM_TEX = 1'b0,
		STREAM_ARITH = 1'b1
	} stream_t;
endpackage
`default_nettype wire

// [hdl/switch_flag_select.sv]
// Picks the switch flag that belongs to the current instruction of the current stream.
`timescale 1ns/10ps
`default_nettype none
module switch_flag_select (
	// Switch maps.
	input wire logic [23:0] tex_map,
	input wire logic [23:0] arith_map_0,
	input wire logic [23:0] arith_map_1,
	input wire logic [23:0] arith_map_2,
	// Lookup.
	input wire logic stream,
	input wire logic [6:0] tex_index,
	input wire logic [6:0] arith_index,
	output logic flag
);
	wire logic [6:0] tex_off = tex_index - stream_switch_pkg::TEX_FLAG_BASE;
	wire logic tex_in_map = (tex_index >= stream_switch_pkg::TEX_FLAG_BASE) &&
		(tex_index <= stream_switch_pkg::TEX_FLAG_LAST);
	wire logic tex_flag = tex_in_map && tex_map[tex_off[2:0]];
	wire logic [6:0] off_1 = arith_index - stream_switch_pkg::ARITH_BASE_1;
	wire logic [6:0] off_2 = arith_index - stream_switch_pkg::ARITH_BASE_2;
	wire logic sel_0 = arith_index < stream_switch_pkg::ARITH_BASE_1;
	wire logic sel_1 = !sel_0 && (arith_index < stream_switch_pkg::ARITH_BASE_2);
	wire logic sel_2 = (arith_index >= stream_switch_pkg::ARITH_BASE_2) &&
		(arith_index <= stream_switch_pkg::ARITH_LAST);
	wire logic flag_0 = sel_0 && arith_map_0[arith_index[4:0]];
	wire logic flag_1 = sel_1 && arith_map_1[off_1[4:0]];
	wire logic flag_2 = sel_2 && arith_map_2[off_2[4:0]];
	assign flag = stream ? (flag_0 | flag_1 | flag_2) : tex_flag;
endmodule // switch_flag_select
`default_nettype wire

// [verif/shader_stream_switch_map_properties.sv]
// Checker of the stream sequencer outputs.
`timescale 1ns/10ps
`default_nettype none
module switch_map_checker (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Sequencer.
	input wire logic seq_start,
	input wire logic start_stream,
	input wire logic instr_issued,
	input wire logic current_stream,
	input wire logic [6:0] tex_index,
	input wire logic [6:0] arith_index,
	input wire logic switch_pulse
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire go;
	assign go = instr_issued & ~seq_start;
	property p_start; seq_start |=> tex_index == 7'h00 && arith_index == 7'h00
		&& current_stream == $past(start_stream); endproperty
	a_start: assert property (p_start) else $error("start did not reset");
	property p_tex; go && !current_stream |=> tex_index == $past(tex_index) + 7'h01
		&& $stable(arith_index); endproperty
	a_tex: assert property (p_tex) else $error("texture index step");
	property p_arith; go && current_stream |=> arith_index == $past(arith_index) + 7'h01
		&& $stable(tex_index); endproperty
	a_arith: assert property (p_arith) else $error("arith index step");
	property p_idle; !instr_issued && !seq_start |=> !switch_pulse && $stable(current_stream)
		&& $stable(tex_index) && $stable(arith_index); endproperty
	a_idle: assert property (p_idle) else $error("change without issue");
	property p_pulse; switch_pulse |-> $past(go) && current_stream != $past(current_stream);
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse without switch");
	property p_low; go && !current_stream && tex_index < 7'h18 |=> !current_stream; endproperty
	a_low: assert property (p_low) else $error("switch below texture 24");
	property p_high; go && current_stream && arith_index > 7'h47 |=> current_stream; endproperty
	a_high: assert property (p_high) else $error("switch above arith 71");
endmodule // switch_map_checker
bind shader_stream_switch_map switch_map_checker switch_map_checker_i (.hclk, .hresetn,
	.seq_start, .start_stream, .instr_issued, .current_stream, .tex_index, .arith_index,
	.switch_pulse);
`default_nettype wire

// [verif/shader_stream_switch_map_test.sv]
// Testbench of the shader stream switch map.
`timescale 1ns/10ps
`default_nettype none
module shader_stream_switch_map_test;
	logic hclk, hresetn, hsel, hwrite, seq_start, start_stream, instr_issued;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire hreadyout, hresp, current_stream, switch_pulse;
	wire [31:0] hrdata;
	wire [6:0] tex_index, arith_index;
	int num_errors = 0, n_checks = 0, cyc = 0;
	logic [23:0] m[4] = '{24'h000081, 24'h800001, 24'h800001, 24'h802000};
	logic [9:0] ad[6] = '{stream_switch_pkg::ADDR_TEX_TO_ARITH_SWITCH_HI,
		stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_0, stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_1,
		stream_switch_pkg::ADDR_ARITH_TO_TEX_SWITCH_2, stream_switch_pkg::ADDR_SEQ_STATUS, 10'h300};
	logic [31:0] ev[6] = '{32'hFF, 32'hFFFFFF, 32'hFFFFFF, 32'hFFFFFF, 32'h0, 32'h0};
	shader_stream_switch_map shader_stream_switch_map_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .seq_start,
		.start_stream, .instr_issued, .current_stream, .tex_index, .arith_index, .switch_pulse);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic run(input logic ss, input int n);
		logic [6:0] t, a;
		logic s, f, go;
		@(posedge hclk);
		seq_start <= 1'b1;
		start_stream <= ss;
		@(posedge hclk);
		seq_start <= 1'b0;
		t = 7'h00;
		a = 7'h00;
		s = ss;
		f = 1'b0;
		for (int k = 0; k <= n; k++) begin
			go = k < n && k % 5 != 4;
			@(posedge hclk);
			instr_issued <= go;
			@(negedge hclk);
			chk("stream", s, current_stream);
			chk("tex index", t, tex_index);
			chk("arith index", a, arith_index);
			chk("switch pulse", f, switch_pulse);
			if (!go) f = 1'b0;
			else if (!s) f = (t >= 24 && t < 32) ? m[0][t - 24] : 1'b0;
			else if (a < 24) f = m[1][a];
			else if (a < 48) f = m[2][a - 24];
			else f = (a < 72) ? m[3][a - 48] : 1'b0;
			if (go && s) a++;
			if (go && !s) t++;
			if (f) s = !s;
		end
		$display("sequence test from stream %0d done", ss);
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			test_done;
		end
	end
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		{hresetn, hwrite, seq_start, start_stream, instr_issued, htrans} = '0;
		{haddr, hwdata} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ad[i], 32'h0);
			chk("reset value", 32'h0, rd);
			bus(1'b1, ad[i], 32'hFFFFFFFF);
			bus(1'b0, ad[i], 32'h0);
			chk("readback", ev[i], rd);
			chk("response", 32'h0, {31'h0, hresp});
		end
		for (int i = 0; i < 4; i++) bus(1'b1, ad[i], {8'h00, m[i]});
		$display("register test done");
		run(1'b0, 800);
		run(1'b1, 60);
		// A reset after the sequence runs must clear arith_to_tex_switch_2 and the sequencer status.
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, ad[3], 32'h0);
		chk("map after reset", 32'h0, rd);
		bus(1'b0, ad[4], 32'h0);
		chk("status after reset", 32'h0, rd);
		$display("reset test done");
		test_done;
	end
endmodule // shader_stream_switch_map_test
`default_nettype wire
